//--- shared/bus_sizing_consts.vh
// Constants for the external bus cycle sizing sequencer.
`ifndef BUS_SIZING_CONSTS_VH
`define BUS_SIZING_CONSTS_VH
// Transfer size codes: bytes still to move in the current segment.
`define SIZE_LONG        2'h0
`define SIZE_BYTE        2'h1
`define SIZE_WORD        2'h2
`define SIZE_THREE       2'h3
// Size acknowledge codes, active low lines [1:0].
`define ACK_WAIT         2'h3
`define ACK_PORT8        2'h2
`define ACK_PORT16       2'h1
`define ACK_RESERVED     2'h0
// Acknowledge option field codes.
`define ACK_FIELD_FAST   4'he
`define ACK_FIELD_EXT    4'hf
// Strobe select: 0 follows address strobe, 1 follows data strobe.
`define STROBE_SELECT_FIELD_ADDRESS     1'h0
`define STROBE_SELECT_FIELD_DATA        1'h1
// Bus monitor limits in system clock cycles, per timeout select code.
`define MON_LIMIT_0      8'd64
`define MON_LIMIT_1      8'd32
`define MON_LIMIT_2      8'd16
`define MON_LIMIT_3      8'd8
// Two states make one system clock cycle.
`define STATES_PER_CLK   8'd2
`endif

//--- rtl/external_bus_cycle_sizing.v
// External bus cycle sequencer with dynamic port sizing and cycle termination.
`timescale 1ns/100ps
`default_nettype none
`include "bus_sizing_consts.vh"
module external_bus_cycle_sizing (
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        req_in,
   input  wire [1:0]  req_size_in,
   input  wire [23:0] req_addr_in,
   input  wire        req_write_in,
   input  wire [31:0] req_wdata_in,
   input  wire [3:0]  ack_field_in,
   input  wire        strobe_select_field_in,
   input  wire        port16_in,
   input  wire        cs_match_in,
   input  wire        monitor_enable_in,
   input  wire [1:0]  monitor_timeout_select_in,
   input  wire [1:0]  size_ack_n_in,
   input  wire        bus_fault_n_in,
   input  wire        halt_n_in,
   input  wire [15:0] data_in,
   output reg         system_clock_out,
   output reg  [23:0] addr_out,
   output reg  [1:0]  transfer_size_out,
   output reg         rw_out,
   output reg         address_strobe_n_out,
   output reg         data_strobe_n_out,
   output reg         chip_select_n_out,
   output reg  [15:0] data_out,
   output reg         data_oe_out,
   output reg         busy_out,
   output reg         done_out,
   output reg         fault_out,
   output reg  [31:0] rdata_out
);
   // ************************************************************
   // State encoding
   // ************************************************************
   localparam ST_IDLE = 9'h001;
   localparam ST_S0   = 9'h002;
   localparam ST_S1   = 9'h004;
   localparam ST_S2   = 9'h008;
   localparam ST_SW   = 9'h010;
   localparam ST_S3   = 9'h020;
   localparam ST_S4   = 9'h040;
   localparam ST_S5   = 9'h080;
   localparam ST_HALT = 9'h100;

   reg [8:0]  state_r;
   reg [8:0]  state_nxt;
   reg [23:0] addr_r;
   reg [2:0]  seg_r;
   reg [2:0]  tot_r;
   reg [31:0] opbuf_r;
   reg [31:0] rbuf_r;
   reg [1:0]  size_r;
   reg        write_r;
   reg [3:0]  ack_field_r;
   reg [3:0]  wait_cnt_r;
   reg [7:0]  mon_cnt_r;
   reg        fault_r;
   reg [1:0]  moved_r;
   reg        ack16_r;

   // ************************************************************
   // Cycle decode
   // ************************************************************
   reg  [1:0] size_code;
   reg  [7:0] mon_limit;
   wire       ext_ack = (size_ack_n_in == `ACK_PORT8) ||
                        (size_ack_n_in == `ACK_PORT16);
   wire       fast    = (ack_field_r == `ACK_FIELD_FAST);
   wire       int_en  = (ack_field_r < `ACK_FIELD_FAST);
   wire       int_ack = fast || (int_en && (wait_cnt_r == 4'h0));
   wire       cyc_ack = ext_ack || int_ack;
   wire       ack16   = ext_ack ? (size_ack_n_in == `ACK_PORT16) : port16_in;
   wire       mon_trip = monitor_enable_in &&
                         (mon_cnt_r >= mon_limit);
   // A fault wins over halt; halt is only looked at after a clean end.
   wire       fault_now = !bus_fault_n_in || mon_trip;
   wire       odd     = addr_r[0];
   // One byte per cycle unless a 16-bit port answers an even address with at least two bytes left in the segment.
   wire [1:0] moved_c = (!ack16 || odd || (seg_r == 3'd1)) ? 2'd1 : 2'd2;
   wire       sampling = (state_r == ST_S2);
   wire       fast_end = sampling && !fault_now && cyc_ack && fast;
   wire       capture  = !write_r && ((state_r == ST_S4) || fast_end);
   wire [1:0] moved_s  = sampling ? moved_c : moved_r;
   wire       ack16_s  = sampling ? ack16 : ack16_r;
   wire [7:0] cur_b    = opbuf_r[31:24];
   wire [7:0] nxt_b    = opbuf_r[23:16];
   wire [2:0] seg_after = seg_r - {1'b0, moved_r};
   wire [2:0] tot_after = tot_r - {1'b0, moved_r};

   always @* begin
      case (seg_r)
         3'd4:    size_code = `SIZE_LONG;
         3'd3:    size_code = `SIZE_THREE;
         3'd2:    size_code = `SIZE_WORD;
         default: size_code = `SIZE_BYTE;
      endcase
   end

   always @* begin
      case (monitor_timeout_select_in)
         2'h0:    mon_limit = `MON_LIMIT_0 * `STATES_PER_CLK;
         2'h1:    mon_limit = `MON_LIMIT_1 * `STATES_PER_CLK;
         2'h2:    mon_limit = `MON_LIMIT_2 * `STATES_PER_CLK;
         default: mon_limit = `MON_LIMIT_3 * `STATES_PER_CLK;
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   // Each state is one clock; a new cycle only starts while the
   // divided clock is low so that S0 always falls on its high half.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (req_in && halt_n_in && !system_clock_out)
               state_nxt = ST_S0;
         end
         ST_S0: state_nxt = ST_S1;
         ST_S1: state_nxt = ST_S2;
         ST_S2: begin
            if (fault_now)
               state_nxt = ST_S5;
            else if (cyc_ack)
               state_nxt = fast ? ST_S5 : ST_S3;
            else
               state_nxt = ST_SW;
         end
         ST_SW: state_nxt = ST_S2;
         ST_S3: state_nxt = ST_S4;
         ST_S4: state_nxt = ST_S5;
         ST_S5: begin
            if (fault_r || (tot_after == 3'd0))
               state_nxt = ST_IDLE;
            else if (!halt_n_in)
               state_nxt = ST_HALT;
            else
               state_nxt = ST_S0;
         end
         ST_HALT: begin
            if (halt_n_in && !system_clock_out)
               state_nxt = ST_S0;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   wire as_nxt = (state_nxt == ST_S1) || (state_nxt == ST_S2) ||
                 (state_nxt == ST_SW) || (state_nxt == ST_S3) ||
                 (state_nxt == ST_S4);
   // Write data strobe waits until data is stable; fast writes never reach it.
   wire ds_wr  = (state_nxt == ST_SW) || (state_nxt == ST_S3) ||
                 (state_nxt == ST_S4);
   wire ds_nxt = write_r ? ds_wr : as_nxt;

   // ************************************************************
   // Sequencer registers
   // ************************************************************
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r     <= ST_IDLE;
         addr_r      <= 24'h000000;
         seg_r       <= 3'd0;
         tot_r       <= 3'd0;
         opbuf_r     <= 32'h00000000;
         rbuf_r      <= 32'h00000000;
         size_r      <= `SIZE_BYTE;
         write_r     <= 1'b0;
         ack_field_r <= `ACK_FIELD_EXT;
         wait_cnt_r  <= 4'h0;
         mon_cnt_r   <= 8'h00;
         fault_r     <= 1'b0;
         moved_r     <= 2'd1;
         ack16_r     <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if ((state_r == ST_IDLE) && (state_nxt == ST_S0)) begin
            addr_r      <= req_addr_in;
            write_r     <= req_write_in;
            size_r      <= req_size_in;
            ack_field_r <= ack_field_in;
            fault_r     <= 1'b0;
            rbuf_r      <= 32'h00000000;
            case (req_size_in)
               `SIZE_LONG: begin
                  opbuf_r <= req_wdata_in;
                  tot_r   <= 3'd4;
                  // A misaligned long word is two misaligned words.
                  seg_r   <= req_addr_in[0] ? 3'd2 : 3'd4;
               end
               `SIZE_WORD: begin
                  opbuf_r <= {req_wdata_in[15:0], 16'h0000};
                  tot_r   <= 3'd2;
                  seg_r   <= 3'd2;
               end
               default: begin
                  opbuf_r <= {req_wdata_in[7:0], 24'h000000};
                  tot_r   <= 3'd1;
                  seg_r   <= 3'd1;
               end
            endcase
         end
         if (state_nxt == ST_S0) begin
            wait_cnt_r <= (state_r == ST_IDLE) ? ack_field_in : ack_field_r;
            mon_cnt_r  <= 8'h00;
         end
         if ((state_r == ST_SW) && (wait_cnt_r != 4'h0))
            wait_cnt_r <= wait_cnt_r - 4'h1;
         if ((state_r == ST_S2) || (state_r == ST_SW)) begin
            if (mon_cnt_r != 8'hff)
               mon_cnt_r <= mon_cnt_r + 8'h01;
         end
         if (sampling) begin
            if (fault_now)
               fault_r <= 1'b1;
            else if (cyc_ack) begin
               moved_r <= moved_c;
               ack16_r <= ack16;
            end
         end
         if (capture) begin
            if (moved_s == 2'd2)
               rbuf_r <= {rbuf_r[15:0], data_in};
            else if (ack16_s && odd)
               rbuf_r <= {rbuf_r[23:0], data_in[7:0]};
            else
               rbuf_r <= {rbuf_r[23:0], data_in[15:8]};
         end
         if ((state_r == ST_S5) && !fault_r) begin
            addr_r  <= addr_r + {22'h000000, moved_r};
            tot_r   <= tot_after;
            seg_r   <= (seg_after == 3'd0) ? tot_after : seg_after;
            opbuf_r <= (moved_r == 2'd2) ? {opbuf_r[15:0], 16'h0000} :
                                           {opbuf_r[23:0], 8'h00};
         end
      end
   end

   // ************************************************************
   // Pin and user outputs
   // ************************************************************
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         system_clock_out     <= 1'b0;
         addr_out             <= 24'h000000;
         transfer_size_out    <= `SIZE_BYTE;
         rw_out               <= 1'b1;
         address_strobe_n_out <= 1'b1;
         data_strobe_n_out    <= 1'b1;
         chip_select_n_out    <= 1'b1;
         data_out             <= 16'h0000;
         data_oe_out          <= 1'b0;
         busy_out             <= 1'b0;
         done_out             <= 1'b0;
         fault_out            <= 1'b0;
         rdata_out            <= 32'h00000000;
      end else begin
         system_clock_out     <= !system_clock_out;
         address_strobe_n_out <= !as_nxt;
         data_strobe_n_out    <= !ds_nxt;
         chip_select_n_out    <= !(cs_match_in &&
            ((strobe_select_field_in == `STROBE_SELECT_FIELD_DATA) ? ds_nxt : as_nxt));
         busy_out  <= (state_nxt != ST_IDLE);
         done_out  <= 1'b0;
         fault_out <= 1'b0;
         if (state_r == ST_S0) begin
            addr_out          <= addr_r;
            transfer_size_out <= size_code;
            rw_out            <= !write_r;
            data_oe_out       <= write_r;
            if (odd || (seg_r == 3'd1))
               data_out <= {cur_b, cur_b};
            else
               data_out <= {cur_b, nxt_b};
         end
         if ((state_nxt == ST_IDLE) || (state_nxt == ST_HALT)) begin
            data_oe_out <= 1'b0;
            rw_out      <= 1'b1;
         end
         if ((state_r == ST_S5) && (state_nxt == ST_IDLE)) begin
            if (fault_r)
               fault_out <= 1'b1;
            else begin
               done_out <= 1'b1;
               case (size_r)
                  `SIZE_LONG: rdata_out <= rbuf_r;
                  `SIZE_WORD: rdata_out <= {16'h0000, rbuf_r[15:0]};
                  default:    rdata_out <= {24'h000000, rbuf_r[7:0]};
               endcase
            end
         end
      end
   end
endmodule // external_bus_cycle_sizing
`default_nettype wire

//--- verif/bus_sizing_chk.sv
// Concurrent checks on the bus cycle sizing sequencer ports.
`timescale 1ns/100ps
`default_nettype none
module bus_sizing_chk (
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic [3:0]  ack_field_in,
   input wire logic        monitor_enable_in,
   input wire logic [1:0]  monitor_timeout_select_in,
   input wire logic [1:0]  size_ack_n_in,
   input wire logic        bus_fault_n_in,
   input wire logic        busy_out,
   input wire logic [23:0] addr_out,
   input wire logic [1:0]  transfer_size_out,
   input wire logic        rw_out,
   input wire logic        address_strobe_n_out,
   input wire logic        data_strobe_n_out,
   input wire logic [15:0] data_out,
   input wire logic        fault_out,
   input wire logic        cs_match_in,
   input wire logic        strobe_select_field_in,
   input wire logic        chip_select_n_out,
   input wire logic        data_oe_out,
   input wire logic        system_clock_out
);
   // Saturating, so a hung cycle cannot wrap round to a small count.
   logic [5:0] low_r;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) low_r <= 6'h00;
      else if (address_strobe_n_out) low_r <= 6'h00;
      else if (low_r != 6'h3f) low_r <= low_r + 6'h01;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_three_offset: assert property (!address_strobe_n_out && transfer_size_out == 2'h3
      |-> addr_out[0]) else $error("Three-byte cycle on even offset.");
   a_byte_dup: assert property (!data_strobe_n_out && !rw_out && transfer_size_out[0]
      |-> data_out[15:8] == data_out[7:0]) else $error("Byte not duplicated.");
   a_wait_state: assert property (!address_strobe_n_out && size_ack_n_in == 2'h3
      && bus_fault_n_in && ack_field_in == 4'hf && !monitor_enable_in
      |=> !address_strobe_n_out) else $error("Cycle ended without acknowledge.");
   a_regular_min: assert property ($rose(address_strobe_n_out) && ack_field_in != 4'he
      && bus_fault_n_in && !monitor_enable_in |-> low_r >= 6'h04)
      else $error("Regular cycle too short.");
   a_fast_short: assert property ($rose(address_strobe_n_out) && ack_field_in == 4'he
      && size_ack_n_in == 2'h3 |-> low_r <= 6'h03) else $error("Fast cycle too long.");
   a_fast_nods: assert property (ack_field_in == 4'he && !rw_out |-> data_strobe_n_out)
      else $error("Data strobe on fast write.");
   a_monitor_limit: assert property (monitor_enable_in
      && monitor_timeout_select_in == 2'h3 |-> low_r <= 6'h18)
      else $error("Bus monitor late.");
   a_fault_wins: assert property ($fell(bus_fault_n_in) && busy_out
      |-> ##[1:8] fault_out) else $error("Fault not taken.");
   a_monitor_mid: assert property (monitor_enable_in
      && monitor_timeout_select_in == 2'h2 |-> low_r <= 6'h24)
      else $error("Bus monitor late on middle limit.");
   a_cs_address: assert property (cs_match_in && !strobe_select_field_in
      |=> chip_select_n_out == address_strobe_n_out)
      else $error("Chip select not following address strobe.");
   a_cs_data: assert property (cs_match_in && strobe_select_field_in
      |=> chip_select_n_out == data_strobe_n_out)
      else $error("Chip select not following data strobe.");
   a_oe_write: assert property (data_oe_out |-> !rw_out)
      else $error("Data lanes driven outside a write.");
   a_clock_half: assert property ($past(rst_n_in)
      |-> system_clock_out != $past(system_clock_out))
      else $error("System clock output did not toggle.");
endmodule // bus_sizing_chk
bind external_bus_cycle_sizing bus_sizing_chk bus_sizing_chk_i (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ack_field_in(ack_field_in),
   .monitor_enable_in(monitor_enable_in), .size_ack_n_in(size_ack_n_in),
   .monitor_timeout_select_in(monitor_timeout_select_in), .bus_fault_n_in(bus_fault_n_in),
   .busy_out(busy_out), .addr_out(addr_out), .transfer_size_out(transfer_size_out),
   .rw_out(rw_out), .address_strobe_n_out(address_strobe_n_out), .data_out(data_out),
   .data_strobe_n_out(data_strobe_n_out), .fault_out(fault_out),
   .cs_match_in(cs_match_in), .strobe_select_field_in(strobe_select_field_in),
   .chip_select_n_out(chip_select_n_out), .data_oe_out(data_oe_out),
   .system_clock_out(system_clock_out));
`default_nettype wire

//--- verif/bus_partner.sv
// Behavioural memory on the sized external bus.
`timescale 1ns/100ps
`default_nettype none
module bus_partner (
   input  wire logic        clk_sys_in,
   input  wire logic        as_n_in,
   input  wire logic        rw_in,
   input  wire logic [1:0]  size_in,
   input  wire logic [23:0] addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        port16_in,
   input  wire logic        mute_in,
   input  wire logic [1:0]  waits_in,
   output var  logic [1:0]  size_ack_n_out,
   output var  logic [15:0] data_out
);
   logic [7:0] wmem [int];
   logic [2:0] log_q [$];
   int         cnt = 0;
   logic       seen = 1'b0;
   initial {size_ack_n_out, data_out} = 18'h30000;
   always @(posedge clk_sys_in) begin
      if (!as_n_in && size_ack_n_out != 2'h3 && !seen) begin
         seen = 1'b1;
         log_q.push_back({size_in, addr_in[0]});
         if (!rw_in) begin
            // An 8-bit port sees only the upper lane.
            if (port16_in && addr_in[0]) wmem[addr_in] = wdata_in[7:0];
            else wmem[addr_in] = wdata_in[15:8];
            if (port16_in && !addr_in[0] && size_in != 2'h1)
               wmem[addr_in + 24'h1] = wdata_in[7:0];
         end
      end
      #1;
      if (as_n_in) {cnt, seen, size_ack_n_out} = {32'h0, 1'b0, 2'h3};
      else begin
         if (!mute_in && cnt >= 2 * waits_in)
            size_ack_n_out = port16_in ? 2'h1 : 2'h2;
         cnt++;
      end
      // Released lanes toggle so a stale value is never mistaken for data.
      if (!as_n_in && rw_in) data_out = port16_in ?
         {8'h3c ^ {addr_in[7:1], 1'b0}, 8'h3c ^ {addr_in[7:1], 1'b1}} :
         {8'h3c ^ addr_in[7:0], 8'hc3 ^ addr_in[7:0]};
      else data_out = ~data_out;
   end
endmodule // bus_partner
`default_nettype wire

//--- verif/external_bus_cycle_sizing_tb.sv
// Self-checking bench for the bus cycle sizing sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "bus_sizing_consts.vh"
module external_bus_cycle_sizing_tb;
   logic        clk_sys_in, rst_n_in, req_in, req_write_in, strobe_select_field_in;
   logic        port16_in, cs_match_in, monitor_enable_in, bus_fault_n_in, halt_n_in;
   logic        system_clock_out, rw_out, address_strobe_n_out, data_strobe_n_out;
   logic        chip_select_n_out, data_oe_out, busy_out, done_out, fault_out, mute;
   logic [1:0]  req_size_in, monitor_timeout_select_in, size_ack_n_in, transfer_size_out, waits;
   logic [3:0]  ack_field_in;
   logic [15:0] data_in, data_out;
   logic [23:0] req_addr_in, addr_out;
   logic [31:0] req_wdata_in, rdata_out;
   logic [33:0] note_q [$];
   // Case: {size, offset, port16}, cycles, size codes, offsets.
   logic [19:0] tab [8] = '{20'h71408, 20'h41400, 20'h91800, 20'h82904,
                            20'hb2908, 20'h12200, 20'h04395, 20'h3499a};
   int          miscompares = 0, check_count = 0, cyc = 0;
   external_bus_cycle_sizing external_bus_cycle_sizing_i (.*);
   bus_partner bus_partner_i (.clk_sys_in(clk_sys_in), .as_n_in(address_strobe_n_out),
      .rw_in(rw_out), .size_in(transfer_size_out), .addr_in(addr_out), .wdata_in(data_out),
      .port16_in(port16_in), .mute_in(mute), .waits_in(waits),
      .size_ack_n_out(size_ack_n_in), .data_out(data_in));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Mode ab: 0 normal, 1 fault with halt in mid-cycle, 2 wait for the monitor,
   // 3 halt alone between cycles.
   task automatic op(input int c, input logic wr, input logic [3:0] fld, input int ab);
      logic [23:0] a;
      logic [31:0] d, v;
      int          n, k;
      a = 24'($urandom) & 24'h0ffffe | 24'(tab[c][17]);
      d = $urandom;
      n = tab[c][19:18] == 2'h1 ? 1 : tab[c][19:18] == 2'h2 ? 2 : 4;
      v = 32'h0;
      for (k = 0; k < n; k++) v = {v[23:0], 8'(a + 24'(k)) ^ 8'h3c};
      note_q.push_back({ab == 1 || ab == 2, !wr && ab != 1 && ab != 2, v});
      bus_partner_i.log_q.delete();
      {waits, port16_in, ack_field_in} = {2'($urandom_range(2, 0)), tab[c][16], fld};
      // Fast writes only work with the chip select on the address strobe.
      strobe_select_field_in = (fld == `ACK_FIELD_FAST) ? `STROBE_SELECT_FIELD_ADDRESS : 1'($urandom);
      {req_size_in, req_addr_in, req_write_in, req_wdata_in} = {tab[c][19:18], a, wr, d};
      req_in = 1'b1;
      for (k = 0; k < 20 && busy_out !== 1'b1; k++) tick(1);
      req_in = 1'b0;
      if (ab == 1) begin
         tick(4);
         {bus_fault_n_in, halt_n_in} = 2'h0;
      end
      // Halt alone parks the operation between cycles until released.
      if (ab == 3) begin
         tick(4);
         halt_n_in = 1'b0;
         tick(20);
         chk("halt busy", busy_out, 1);
         chk("halt strobe", address_strobe_n_out, 1);
         halt_n_in = 1'b1;
      end
      for (k = 0; k < 500 && busy_out !== 1'b0; k++) tick(1);
      chk("idle", busy_out, 0);
      {bus_fault_n_in, halt_n_in} = 2'h3;
      if (mute) return;
      chk("cycles", bus_partner_i.log_q.size(), tab[c][15:12]);
      for (k = 0; k < tab[c][15:12]; k++)
         chk("size", bus_partner_i.log_q[k], {tab[c][11 - 2 * k -: 2], tab[c][3 - k]});
      for (k = 0; k < n && wr; k++)
         chk("wbyte", bus_partner_i.wmem[a + 24'(k)], 8'(d >> (8 * (n - 1 - k))));
   endtask
   // Results are matched against the oldest note as they appear.
   always @(posedge clk_sys_in) begin
      logic [33:0] e;
      if (done_out === 1'b1 || fault_out === 1'b1) begin
         e = note_q.size() ? note_q.pop_front() : 34'h0;
         chk("fault", fault_out, e[33]);
         if (e[32]) chk("rdata", rdata_out, e[31:0]);
      end
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up;
      end
   end
   initial forever #50 clk_sys_in = ~clk_sys_in;
   //***********************************************************
   // Scenarios
   //***********************************************************
   initial begin
      {clk_sys_in, rst_n_in, req_in, req_write_in, strobe_select_field_in} = 5'h00;
      {port16_in, cs_match_in, monitor_enable_in, bus_fault_n_in, halt_n_in} = 5'h1b;
      {req_size_in, monitor_timeout_select_in, req_addr_in, req_wdata_in} = 60'h3 << 56;
      {ack_field_in, mute, waits} = {`ACK_FIELD_EXT, 1'b0, 2'h0};
      void'($urandom(32'h9160c24c));
      tick(6);
      rst_n_in = 1'b1;
      tick(2);
      for (int c = 0; c < 8; c++)
         for (int w = 0; w < 2; w++) op(c, w[0], `ACK_FIELD_EXT, 0);
      $display("Sizing cases finished");
      mute = 1'b1;
      op(2, 1'b0, `ACK_FIELD_FAST, 0);
      op(2, 1'b1, `ACK_FIELD_FAST, 0);
      op(5, 1'b0, 4'h2, 0);
      mute = 1'b0;
      op(6, 1'b0, 4'h3, 0);
      op(6, 1'b0, `ACK_FIELD_EXT, 3);
      $display("Internal acknowledge finished");
      {mute, monitor_enable_in} = 2'h3;
      op(3, 1'b0, `ACK_FIELD_EXT, 2);
      monitor_timeout_select_in = 2'h2;
      op(3, 1'b0, `ACK_FIELD_EXT, 2);
      monitor_enable_in = 1'b0;
      op(4, 1'b0, `ACK_FIELD_EXT, 1);
      $display("Abort cases finished");
      tick(4);
      chk("notes", note_q.size(), 0);
      wrap_up;
   end
endmodule // external_bus_cycle_sizing_tb
`default_nettype wire
